// >>> verilog/adc_bus_pkg.sv
/*
  Shared constants and types for the converter result bus multiplexer:
  register offsets, field positions, reset values and interface modes.
  Assumes a 32-bit AHB-Lite register bus and an 18-bit result word.
*/
package adc_bus_pkg;

  // Result and bus geometry
  localparam int RESULT_W = 18;
  localparam int PIN_W = 18;
  localparam int SYNC_W = 8;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] RESULT_OFS = 8'h08;

  // Control fields and reset value
  localparam int CTRL_FREEZE_BIT = 0;
  localparam logic CTRL_FREEZE_RST = 1'b0;

  // Status fields
  localparam int ST_MODE_LSB = 0;
  localparam int ST_BUS_EN_BIT = 2;
  localparam int ST_CODING_BIT = 3;
  localparam int ST_WORD_BIT = 4;
  localparam int ST_BYTE_BIT = 5;
  localparam int ST_INTREF_BIT = 6;
  localparam int ST_REFBUF_BIT = 7;
  localparam int ST_EXTREF_BIT = 8;

  // Positions inside the synchroniser vector
  localparam int SY_CS_N = 0;
  localparam int SY_RD_N = 1;
  localparam int SY_SEL_LO = 2;
  localparam int SY_SEL_HI = 3;
  localparam int SY_REF_PD = 4;
  localparam int SY_BUF_PD = 5;
  localparam int SY_CODING = 6;
  localparam int SY_WORD = 7;

  // Pin positions that turn into inputs outside 18-bit mode; the byte pin is driven in 16-bit mode too
  localparam int PIN_CODING = 0;
  localparam int PIN_WORD = 1;
  localparam int PIN_BYTE = 2;

  // Reset values of pin outputs and of the held result
  localparam logic [PIN_W-1:0] DOUT_RST = 18'h00000;
  localparam logic [PIN_W-1:0] DOE_N_RST = 18'h3ffff;
  localparam logic [RESULT_W-1:0] RESULT_RST = 18'h00000;

  // Interface modes, in the order of the two select pins
  typedef enum logic [1:0] {
    MODE_PAR18,
    MODE_PAR16,
    MODE_PAR8,
    MODE_SERIAL
  } iface_mode_t;

endpackage

// >>> verilog/pin_sync.sv
/*
  Two-flop synchroniser for a group of level inputs.
  Assumes the inputs are quasi-static levels; a pulse shorter than an hclk period can be lost.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // Levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta_reg;
    logic [W-1:0] stable_reg;
  } sync_state_t;

  sync_state_t st;
  sync_state_t st_next;

  // The first stage feeds only the second stage
  always_comb begin
    st_next = st;
    if (ce) begin
      st_next.meta_reg = async_in;
      st_next.stable_reg = st.meta_reg;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= st_next;
    end
  end

  assign sync_out = st.stable_reg;

endmodule

// >>> verilog/result_coder.sv
/*
  Output coding of the held result: straight binary or twos complement.
  Assumes the converter core produces straight binary.
*/
`timescale 1ns/1ps
module result_coder
  import adc_bus_pkg::*;
(
  // Controls
  input wire iface_mode_t mode,
  input wire logic coding_select,
  // Words
  input wire logic [RESULT_W-1:0] raw,
  output logic [RESULT_W-1:0] coded
);

  // Twos complement is binary with the top bit flipped; 18-bit mode is raw
  always_comb begin
    coded = raw;
    if (mode != MODE_PAR18 && !coding_select) begin
      coded[RESULT_W-1] = ~raw[RESULT_W-1];
    end
  end

endmodule

// >>> verilog/adc_result_bus_mux.sv
/*
  Result bus multiplexer: holds the last conversion result and shows it
  on an 18-, 16- or 8-bit parallel bus or hands it to the serial port,
  with reference power-down controls and an AHB-Lite register slave.
  Assumes conversion results arrive on hclk; pins are asynchronous.
*/
// Design decisions made here: the AHB-Lite register port and the address map.
// Operation
// - Mode 00 drives result bit n on data pin n, no address pins.
// - 16-bit, word select low: result bits 2..17 on pins 2..17.
// - 16-bit, word select high: bits 0,1 on pins 2,3, zeros above.
// - 8-bit, both selects low: bits 10..17 on pins 10..17.
// - 8-bit, word low byte high: bits 2..9 on pins 10..17.
// - 8-bit, word select high: low byte holds bits 0,1, zeros else.
// - Mode 11 floats parallel pins and routes result to serial port.
// - Reference power-down high disables internal reference.
// - Output bus enabled only while chip select and read are low.
// - Selectable coding applies in all modes but 18-bit parallel.
`timescale 1ns/1ps
module adc_result_bus_mux
  import adc_bus_pkg::*;
(
  // Clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Conversion result from the core
  input wire logic conv_valid,
  input wire logic [RESULT_W-1:0] conv_data,
  // Host pins
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic iface_sel_hi,
  input wire logic iface_sel_lo,
  input wire logic ref_powerdown,
  input wire logic refbuf_powerdown,
  // Data pins
  input wire logic [PIN_W-1:0] data_in,
  output logic [PIN_W-1:0] data_out,
  output logic [PIN_W-1:0] data_oe_n,
  // Serial port hand-off
  output logic serial_en,
  output logic [RESULT_W-1:0] serial_word,
  // Reference controls
  output logic int_ref_en,
  output logic ref_buf_en,
  output logic ext_ref_required
);

  typedef struct packed {
    logic [RESULT_W-1:0] result_reg;
    logic [PIN_W-1:0] dout_reg;
    logic [PIN_W-1:0] doe_n_reg;
    logic [RESULT_W-1:0] ser_word_reg;
    logic ser_en_reg;
    logic freeze_reg;
    logic wr_pend_reg;
    logic [7:0] waddr_reg;
    logic [31:0] hrdata_reg;
    logic int_ref_reg;
    logic buf_en_reg;
  } mux_state_t;

  mux_state_t st;
  mux_state_t st_next;
  logic [SYNC_W-1:0] sync_raw;
  logic [SYNC_W-1:0] sync_v;
  logic byte_sync_v;
  iface_mode_t mode;
  logic bus_en;
  logic coding_s;
  logic word_s;
  logic byte_s;
  logic [RESULT_W-1:0] coded;
  logic addr_ok;
  logic [31:0] status_word;
  logic [31:0] rd_word;

  // Pins cross into hclk before anything looks at them; the selects are
  // stored active high so the cleared synchroniser reads as an idle bus
  assign sync_raw[SY_CS_N] = !cs_n;
  assign sync_raw[SY_RD_N] = !rd_n;
  assign sync_raw[SY_SEL_LO] = iface_sel_lo;
  assign sync_raw[SY_SEL_HI] = iface_sel_hi;
  assign sync_raw[SY_REF_PD] = ref_powerdown;
  assign sync_raw[SY_BUF_PD] = refbuf_powerdown;
  assign sync_raw[SY_CODING] = data_in[PIN_CODING];
  assign sync_raw[SY_WORD] = data_in[PIN_WORD];

  pin_sync #(.W(SYNC_W)) u_pin_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .async_in(sync_raw),
    .sync_out(sync_v)
  );

  // Byte select pin has its own pair, since it is an input only in 8-bit and serial mode
  pin_sync #(.W(1)) u_byte_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .async_in(data_in[PIN_BYTE]),
    .sync_out(byte_sync_v)
  );

  assign mode = iface_mode_t'({sync_v[SY_SEL_HI], sync_v[SY_SEL_LO]});
  assign bus_en = sync_v[SY_CS_N] && sync_v[SY_RD_N];
  assign coding_s = sync_v[SY_CODING];
  assign word_s = sync_v[SY_WORD];
  assign byte_s = byte_sync_v;

  result_coder u_coder (
    .mode(mode),
    .coding_select(coding_s),
    .raw(st.result_reg),
    .coded(coded)
  );

  // Register map decode and read mux
  assign addr_ok = hsel && htrans[1] && hready;
  always_comb begin
    status_word = '0;
    status_word[ST_MODE_LSB +: 2] = mode;
    status_word[ST_BUS_EN_BIT] = bus_en;
    status_word[ST_CODING_BIT] = coding_s;
    status_word[ST_WORD_BIT] = word_s;
    status_word[ST_BYTE_BIT] = byte_s;
    status_word[ST_INTREF_BIT] = st.int_ref_reg;
    status_word[ST_REFBUF_BIT] = st.buf_en_reg;
    status_word[ST_EXTREF_BIT] = !st.int_ref_reg;
    unique case (haddr[7:0])
      CTRL_OFS: rd_word = {31'h00000000, st.freeze_reg};
      STATUS_OFS: rd_word = status_word;
      RESULT_OFS: rd_word = {14'h0000, st.result_reg};
      default: rd_word = 32'h00000000; // Unmapped reads return zero
    endcase
  end

  // Next state: bus slave, result holding and pin lanes
  always_comb begin
    st_next = st;
    if (ce) begin
      // Address phase captured; read data registered for the data phase
      st_next.wr_pend_reg = addr_ok && hwrite;
      st_next.waddr_reg = haddr[7:0];
      if (addr_ok && !hwrite) begin
        st_next.hrdata_reg = rd_word;
      end
      // Software writes land in the data phase
      if (st.wr_pend_reg) begin
        if (st.waddr_reg == CTRL_OFS) begin
          st_next.freeze_reg = hwdata[CTRL_FREEZE_BIT];
        end
        if (st.waddr_reg == RESULT_OFS) begin
          st_next.result_reg = hwdata[RESULT_W-1:0];
        end
      end
      // A fresh conversion wins over a software load unless frozen
      if (conv_valid && !st.freeze_reg) begin
        st_next.result_reg = conv_data;
      end

      // Reference controls follow the synchronised pins
      st_next.int_ref_reg = !sync_v[SY_REF_PD];
      st_next.buf_en_reg = !sync_v[SY_BUF_PD];

      // Lanes default to floating with zero data
      st_next.dout_reg = DOUT_RST;
      st_next.doe_n_reg = DOE_N_RST;
      st_next.ser_en_reg = 1'b0;
      st_next.ser_word_reg = coded;
      unique case (mode)
        MODE_PAR18: begin
          // Raw result, every pin an output
          st_next.dout_reg = st.result_reg;
          if (bus_en) begin
            st_next.doe_n_reg = '0;
          end
        end
        MODE_PAR16: begin
          if (word_s) begin
            st_next.dout_reg[3:2] = coded[1:0];
          end else begin
            st_next.dout_reg[17:2] = coded[17:2];
          end
          if (bus_en) begin
            st_next.doe_n_reg[17:2] = '0;
          end
        end
        MODE_PAR8: begin
          // Pins 0..9 float; only the top byte lanes are driven
          if (word_s && byte_s) begin
            st_next.dout_reg[17:16] = coded[1:0];
          end else if (word_s) begin
            st_next.dout_reg[11:10] = coded[1:0];
          end else if (byte_s) begin
            st_next.dout_reg[17:10] = coded[9:2];
          end else begin
            st_next.dout_reg[17:10] = coded[17:10];
          end
          if (bus_en) begin
            st_next.doe_n_reg[17:10] = '0;
          end
        end
        MODE_SERIAL: begin
          // Parallel pins stay floating; serial side takes the word
          st_next.ser_en_reg = bus_en;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
      st.doe_n_reg <= DOE_N_RST;
      st.freeze_reg <= CTRL_FREEZE_RST;
      st.result_reg <= RESULT_RST;
    end else begin
      st <= st_next;
    end
  end

  // Zero wait state; a low clock enable stretches the transfer instead
  assign hreadyout = ce;
  assign hresp = 1'b0;
  assign hrdata = st.hrdata_reg;
  assign data_out = st.dout_reg;
  assign data_oe_n = st.doe_n_reg;
  assign serial_en = st.ser_en_reg;
  assign serial_word = st.ser_word_reg;
  assign int_ref_en = st.int_ref_reg;
  assign ref_buf_en = st.buf_en_reg;
  assign ext_ref_required = !st.int_ref_reg;

  // Checks of the lane map against the held result
  a_full_width_map: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ce && mode == MODE_PAR18 && bus_en
      |=> data_out == $past(st.result_reg) && data_oe_n == 18'h00000)
    else $error("18-bit lanes do not match result");
  a_coding_pin_in: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ce && mode != MODE_PAR18 |=> data_oe_n[0] && data_oe_n[1])
    else $error("coding pin driven outside 18-bit mode");
  a_high_word: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ce && mode == MODE_PAR16 && !word_s && bus_en
      |=> data_out[17:2] == $past(coded[17:2]) && !data_oe_n[2])
    else $error("high word lanes wrong");
  a_low_word: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ce && mode == MODE_PAR16 && word_s
      |=> data_out[3:2] == $past(coded[1:0]) && data_out[17:4] == '0)
    else $error("low word lanes wrong");
  a_byte_float: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ce && mode == MODE_PAR8 |=> data_oe_n[9:0] == 10'h3ff)
    else $error("pins below 10 driven in 8-bit mode");
  a_high_byte: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ce && mode == MODE_PAR8 && !word_s && !byte_s
      |=> data_out[17:10] == $past(coded[17:10]))
    else $error("high byte wrong");
  a_mid_byte: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ce && mode == MODE_PAR8 && !word_s && byte_s
      |=> data_out[17:10] == $past(coded[9:2]))
    else $error("middle byte wrong");
  a_low_byte: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ce && mode == MODE_PAR8 && word_s
      |=> $countones(data_out) <= 2 &&
          (data_out[11:10] | data_out[17:16]) == $past(coded[1:0]))
    else $error("low byte wrong");
  a_serial_float: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ce && mode == MODE_SERIAL
      |=> data_oe_n == 18'h3ffff && serial_en == $past(bus_en))
    else $error("parallel pins driven in serial mode");
  a_ref_off: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ce && sync_v[SY_REF_PD] |=> !int_ref_en && ext_ref_required)
    else $error("internal reference left on");
  a_bus_gate: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ce && !bus_en |=> data_oe_n == 18'h3ffff && !serial_en)
    else $error("bus enabled without select and read");
  a_coding_flip: assert property (
    @(posedge hclk) disable iff (!hresetn)
    mode != MODE_PAR18 && !coding_s
      |-> coded[17] != st.result_reg[17])
    else $error("twos complement not applied");
  a_result_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ce && conv_valid && !st.freeze_reg
      |=> st.result_reg == $past(conv_data))
    else $error("result not latched");

endmodule

// >>> dv/host_pin_model.sv
/*
  Host pin model: drives chip select, read, mode, select and power-down
  pins of the result bus, and resolves the shared data pins.
  Assumes bench commands change just after a rising edge of hclk.
*/
`timescale 1ns/1ps
module host_pin_model
  import adc_bus_pkg::*;
(
  // Clock and bench commands
  input wire logic hclk,
  input wire logic [1:0] mode,
  input wire logic rd_on,
  input wire logic [2:0] sel,
  input wire logic [1:0] pd,
  // Device pins
  output logic cs_n,
  output logic rd_n,
  output logic iface_sel_hi,
  output logic iface_sel_lo,
  output logic ref_powerdown,
  output logic refbuf_powerdown,
  output logic [PIN_W-1:0] data_in,
  input wire logic [PIN_W-1:0] data_out,
  input wire logic [PIN_W-1:0] data_oe_n
);
  // Pins move just after an edge, as a real host would; the first edge
  // inside reset already leaves the bus idle
  always @(posedge hclk) begin
    cs_n <= ~rd_on;
    rd_n <= ~rd_on;
    {iface_sel_hi, iface_sel_lo} <= mode;
    ref_powerdown <= pd[0];
    // Buffer kept up while the internal reference is in use
    refbuf_powerdown <= pd[0] & pd[1];
  end

  // Device wins where it drives; floating pins 0..2 take the bench selects, the
  // others show the inverse of the device value so a stale level can never pass for data
  always_comb begin
    data_in = ~data_out;
    data_in[2:0] = sel;
    data_in = (data_oe_n & data_in) | (~data_oe_n & data_out);
  end
endmodule

// >>> dv/test_adc_result_bus_mux.sv
/*
  Self-checking bench for the result bus multiplexer: register access
  over AHB-Lite, every bus mode and select, bus gating and references.
  Assumes ce tied high, so the slave answers with no wait states.
*/
`timescale 1ns/1ps
module test_adc_result_bus_mux;
  import adc_bus_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, conv_valid;
  logic [31:0] haddr, hwdata, hrdata, rdat;
  logic [1:0] htrans, mode, pd;
  logic [2:0] hsize, sel;
  logic rd_on, cs_n, rd_n, sel_hi, sel_lo, ref_pd, buf_pd, serial_en;
  logic int_ref_en, ref_buf_en, ext_ref_required;
  logic [17:0] conv_data, data_in, data_out, data_oe_n, serial_word, r;
  logic [35:0] e;
  logic [1:0] pv [3];
  int fail_count, samples_checked;

  // Free-running 20 MHz clock
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  adc_result_bus_mux adc_result_bus_mux_inst (.hclk(hclk),
    .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .conv_valid(conv_valid), .conv_data(conv_data),
    .cs_n(cs_n), .rd_n(rd_n), .iface_sel_hi(sel_hi),
    .iface_sel_lo(sel_lo), .ref_powerdown(ref_pd),
    .refbuf_powerdown(buf_pd), .data_in(data_in), .data_out(data_out),
    .data_oe_n(data_oe_n), .serial_en(serial_en),
    .serial_word(serial_word), .int_ref_en(int_ref_en),
    .ref_buf_en(ref_buf_en), .ext_ref_required(ext_ref_required));

  host_pin_model host_pin_model_inst (.hclk(hclk), .mode(mode),
    .rd_on(rd_on), .sel(sel), .pd(pd), .cs_n(cs_n), .rd_n(rd_n),
    .iface_sel_hi(sel_hi), .iface_sel_lo(sel_lo),
    .ref_powerdown(ref_pd), .refbuf_powerdown(buf_pd),
    .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n));

  task stop_test;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task check(input string what, input logic [31:0] seen,
             input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Bounded wait for hready at a rising edge
  task wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        fail_count++;
        stop_test;
      end
      @(posedge hclk);
    end
  endtask

  // One single word transfer; read data lands in rdat
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy;
    rdat = hrdata;
    check("hresp", hresp, 1'b0);
  endtask

  // Pin settings pass the model, two sync flops and the output stage
  task pins(input logic [1:0] m, input logic on, input logic [2:0] s,
            input logic [1:0] p);
    mode <= m;
    rd_on <= on;
    sel <= s;
    pd <= p;
    repeat (10) @(posedge hclk);
  endtask

  task pulse(input logic [17:0] d);
    conv_valid <= 1'b1;
    conv_data <= d;
    @(posedge hclk);
    conv_valid <= 1'b0;
  endtask

  // Expected {oe_n, data}; twos complement is the MSB inverted
  function automatic logic [35:0] exp_pins(input logic [1:0] m,
    input logic ws, input logic bs, input logic cd, input logic [17:0] v);
    logic [17:0] c, o, z;
    c = (cd || m == 2'h0) ? v : {~v[17], v[16:0]};
    o = 18'h00000;
    z = 18'h3ffff;
    case (m)
      2'h0: begin
        o = c;
        z = 18'h00000;
      end
      2'h1: begin
        z = 18'h00003;
        o = ws ? {14'h0000, c[1:0], 2'h0} : {c[17:2], 2'h0};
      end
      2'h2: begin
        z = 18'h003ff;
        case ({ws, bs})
          2'h0: o[17:10] = c[17:10];
          2'h1: o[17:10] = c[9:2];
          2'h2: o[11:10] = c[1:0];
          default: o[17:16] = c[1:0];
        endcase
      end
      default: ;
    endcase
    return {z, o};
  endfunction

  initial begin
    {hresetn, hsel, hwrite, conv_valid, rd_on} = 5'h00;
    {haddr, hwdata, conv_data} = 82'h0;
    {htrans, mode, pd, sel} = 9'h000;
    hsize = 3'h2;
    {fail_count, samples_checked} = 64'h0;
    pv = '{2'h0, 2'h1, 2'h3};
    r = 18'h2b3c5;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check("oe_n", data_oe_n, 18'h3ffff);
    ahb(1'b0, RESULT_OFS, 32'h0);
    check("result", rdat, 32'h0);
    ahb(1'b0, 8'h0c, 32'h0);
    check("unmapped", rdat, 32'h0);
    $display("test reset done");
    // Result register: software load, converter load, freeze
    ahb(1'b1, RESULT_OFS, 32'h0002a5c3);
    ahb(1'b0, RESULT_OFS, 32'h0);
    check("sw load", rdat, 32'h0002a5c3);
    pulse(18'h15a3c);
    ahb(1'b0, RESULT_OFS, 32'h0);
    check("conv load", rdat, 32'h00015a3c);
    ahb(1'b1, CTRL_OFS, 32'h1);
    pulse(18'h3ffff);
    ahb(1'b0, RESULT_OFS, 32'h0);
    check("frozen", rdat, 32'h00015a3c);
    ahb(1'b1, CTRL_OFS, 32'h0);
    pulse(r);
    $display("test result done");
    // Every mode with every select and coding
    for (int m = 0; m < 4; m++) begin
      for (int s = 0; s < 8; s++) begin
        pins(m[1:0], 1'b1, s[2:0], 2'h0);
        e = exp_pins(m[1:0], s[1], s[2], s[0], r);
        check("data_out", data_out, e[17:0]);
        check("oe_n", data_oe_n, e[35:18]);
        check("serial_en", serial_en, m == 3);
        if (m == 3)
          check("serial", serial_word, s[0] ? r : r ^ 18'h20000);
      end
    end
    $display("test modes done");
    // Bus gating and converter result reaching the pins
    pins(2'h3, 1'b0, 3'h0, 2'h0);
    check("serial_en", serial_en, 1'b0);
    pins(2'h0, 1'b0, 3'h0, 2'h0);
    check("oe_n", data_oe_n, 18'h3ffff);
    pins(2'h0, 1'b1, 3'h0, 2'h0);
    pulse(18'h0f0f1);
    repeat (3) @(posedge hclk);
    check("conv pins", data_out, 18'h0f0f1);
    $display("test gating done");
    // Reference power-down combinations
    for (int i = 0; i < 3; i++) begin
      pins(2'h0, 1'b0, 3'h0, pv[i]);
      check("int_ref", int_ref_en, !pv[i][0]);
      check("ext_ref", ext_ref_required, pv[i][0]);
      check("ref_buf", ref_buf_en, !(pv[i][0] && pv[i][1]));
    end
    ahb(1'b0, STATUS_OFS, 32'h0);
    check("status", rdat[8:0], 9'h100);
    $display("test reference done");
    stop_test;
  end
endmodule
